// ==== inc/bmds_defines.svh ====
// Purpose: shared constants of the boot mode decode sequencer
// Assumes: included by bare name, definitions only
// Notes: addresses other than the rom base are byte addresses in level-2 memory
`ifndef BMDS_DEFINES_SVH
`define BMDS_DEFINES_SVH
// reserved boot loader region, first and last byte
`define BMDS_REGION_BASE 32'h0087_2DC0
`define BMDS_REGION_END 32'h0087_FFFF
// rom version string at the bottom of the region
`define BMDS_VERSION_BASE 32'h0087_2DC0
`define BMDS_VERSION_BYTES 32'h0000_0040
// progress stack, copies kept on mode change
`define BMDS_PROGRESS_BASE 32'h0087_32E0
`define BMDS_PROGRESS_BYTES 32'h0000_0020
// boot parameter table, filled with fixed values
`define BMDS_PARAM_TBL 32'h0087_3680
`define BMDS_PARAM_WORDS 4'h3
// rom base address for public boot
`define BMDS_ROM_BASE 32'h20B0_0000
// strap field positions
`define BMDS_DEV_MSB 2
`define BMDS_CFG_MSB 9
`define BMDS_CFG_LSB 3
`define BMDS_PLLM_MSB 12
`define BMDS_PLLM_LSB 10
`define BMDS_SDM_MSB 9
`define BMDS_SDM_LSB 8
`define BMDS_SUB_MSB 5
`define BMDS_SUB_LSB 4
`define BMDS_I2C_PASSIVE_BIT 10
// reset value of the remembered mode, matches no mode
`define BMDS_EXT_NONE 7'h7F
`endif

// ==== inc/bmds_pkg.sv ====
// Purpose: types of the boot mode decode sequencer
// Assumes: nothing
// Notes: sequence states follow a gray path
package bmds_pkg;
    // boot sequence states
    typedef enum logic [2:0] {
        BMDS_ST_HOLD = 3'h0,
        BMDS_ST_LATCH = 3'h1,
        BMDS_ST_INIT = 3'h3,
        BMDS_ST_VERSION = 3'h2,
        BMDS_ST_PROGRESS = 3'h6,
        BMDS_ST_RELEASE = 3'h7,
        BMDS_ST_RUN = 3'h5
    } bmds_state_t;
    // boot device codes from the low strap bits
    typedef enum logic [2:0] {
        BMDS_DEV_EMIF = 3'h0,
        BMDS_DEV_SRIO = 3'h1,
        BMDS_DEV_ETH_CORE = 3'h2,
        BMDS_DEV_ETH_SERDES = 3'h3,
        BMDS_DEV_PCIE = 3'h4,
        BMDS_DEV_I2C = 3'h5,
        BMDS_DEV_SPI = 3'h6,
        BMDS_DEV_C2C = 3'h7
    } bmds_dev_t;
    // extended boot mode codes, decimal values
    typedef enum logic [6:0] {
        BMDS_EXT_ETH = 7'h0A,
        BMDS_EXT_SRIO = 7'h14,
        BMDS_EXT_PCIE = 7'h1E,
        BMDS_EXT_I2CM = 7'h28,
        BMDS_EXT_I2CP = 7'h29,
        BMDS_EXT_SPI = 7'h32,
        BMDS_EXT_C2C = 7'h3C,
        BMDS_EXT_EMIF = 7'h46,
        BMDS_EXT_SLEEP = 7'h64
    } bmds_ext_t;
endpackage

// ==== src/bmds_sync.sv ====
// Purpose: two flop synchroniser for pin levels
// Assumes: inputs are slow levels
// Notes: clears to zero under reset
`default_nettype none
module bmds_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r; // first stage, read only by second
    logic [WIDTH-1:0] sync_r; // second stage
    // two stage capture
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end
    assign o_sync = sync_r;
endmodule
`default_nettype wire

// ==== src/bmds_decode.sv ====
// Purpose: decode the latched strap field
// Assumes: strap value is stable while used
// Notes: purely combinational
`include "bmds_defines.svh"
`default_nettype none
module bmds_decode (
    input wire logic [12:0] i_strap,
    output bmds_pkg::bmds_ext_t o_ext_mode,
    output logic o_pll_ref_serdes,
    output logic [2:0] o_pll_mult,
    output logic [6:0] o_dev_cfg
);
    bmds_pkg::bmds_dev_t dev; // selected boot device
    // device code and per-device fields
    always_comb begin
        dev = bmds_pkg::bmds_dev_t'(i_strap[`BMDS_DEV_MSB:0]); // RULE8
        o_dev_cfg = i_strap[`BMDS_CFG_MSB:`BMDS_CFG_LSB]; // RULE17
        o_pll_ref_serdes = 1'b0;
        o_pll_mult = 3'h0;
        case (dev) // RULE9 RULE12 RULE13
            bmds_pkg::BMDS_DEV_EMIF: begin
                // sub mode 1 is memory boot, else sleep
                if (i_strap[`BMDS_SUB_MSB:`BMDS_SUB_LSB] == 2'h1) begin
                    o_ext_mode = bmds_pkg::BMDS_EXT_EMIF;
                end else begin
                    o_ext_mode = bmds_pkg::BMDS_EXT_SLEEP;
                end
            end
            bmds_pkg::BMDS_DEV_SRIO: o_ext_mode = bmds_pkg::BMDS_EXT_SRIO;
            bmds_pkg::BMDS_DEV_ETH_CORE: begin
                o_ext_mode = bmds_pkg::BMDS_EXT_ETH;
                o_pll_mult = i_strap[`BMDS_PLLM_MSB:`BMDS_PLLM_LSB]; // RULE10
            end
            bmds_pkg::BMDS_DEV_ETH_SERDES: begin
                o_ext_mode = bmds_pkg::BMDS_EXT_ETH;
                o_pll_ref_serdes = 1'b1; // RULE11
                o_pll_mult = {1'b0, i_strap[`BMDS_SDM_MSB:`BMDS_SDM_LSB]}; // RULE11
            end
            bmds_pkg::BMDS_DEV_PCIE: o_ext_mode = bmds_pkg::BMDS_EXT_PCIE;
            bmds_pkg::BMDS_DEV_I2C: begin
                // one extension bit picks passive over master
                if (i_strap[`BMDS_I2C_PASSIVE_BIT]) begin
                    o_ext_mode = bmds_pkg::BMDS_EXT_I2CP;
                end else begin
                    o_ext_mode = bmds_pkg::BMDS_EXT_I2CM;
                end
            end
            bmds_pkg::BMDS_DEV_SPI: o_ext_mode = bmds_pkg::BMDS_EXT_SPI;
            default: o_ext_mode = bmds_pkg::BMDS_EXT_C2C;
        endcase
    end
endmodule
`default_nettype wire

// ==== src/bmds_top.sv ====
// Purpose: boot sequencer, strap decode and core release
// Assumes: core side inputs run on i_clock
// Notes: pins pass a two flop synchroniser first
// Contract
// RULE1: boot starts on release of any reset
// RULE2: local core reset leaves controller untouched
// RULE3: fill fixed values, load memory sections
// RULE4: reserve region 0x00872DC0..0x0087FFFF during boot
// RULE5: version string 0x40 bytes at 0x00872DC0
// RULE6: progress stack 0x20 bytes at 0x008732E0
// RULE7: core 0 uses 13-bit latched strap value
// RULE8: low three bits pick boot device
// RULE9: device codes 0,1,4,5,6,7 decoded as listed
// RULE10: code 2: ethernet, core clock, bits 12:10
// RULE11: code 3: ethernet, serdes clock, bits 9:8
// RULE12: extended codes ethernet 10, srio 20, pcie 30
// RULE13: i2c 40/41, spi 50, link 60, mem 70, sleep 100
// RULE14: core 0 runs rom then entry point
// RULE15: other cores idle until core 0 interrupt
// RULE16: secure: secure rom, authenticate before entry
// RULE17: bits 9:3 carry device dependent configuration
// RULE18: straps latched into status word at release
`include "bmds_defines.svh"
`default_nettype none
module bmds_top #(
    parameter int N_CORES = 2,
    parameter logic [31:0] SECURE_ROM_BASE = 32'h20B1_0000,
    parameter logic [23:0] VERSION_TAG = 24'h5A5A5A // arbitrary value
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [12:0] i_boot_strap_config,
    input wire logic i_warm_reset_n,
    input wire logic i_system_reset_n,
    input wire logic i_secure_device,
    input wire logic [N_CORES-1:0] i_local_reset_n,
    input wire logic i_entry_valid,
    input wire logic [31:0] i_entry_point,
    input wire logic i_auth_ok,
    input wire logic [N_CORES-2:0] i_core0_ipi,
    input wire logic i_l2_wr,
    input wire logic [31:0] i_l2_addr,
    output logic o_boot_busy,
    output logic [12:0] o_device_status_word,
    output logic [6:0] o_ext_mode,
    output logic o_pll_ref_serdes,
    output logic [2:0] o_pll_mult,
    output logic [6:0] o_dev_cfg,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_data,
    output logic [N_CORES-1:0] o_core_rst_n,
    output logic [31:0] o_core0_pc,
    output logic o_core0_secure,
    output logic [N_CORES-2:0] o_core_idle,
    output logic o_region_lock,
    output logic o_l2_violation
);
    // synchronised pins: straps, two reset levels, secure strap
    logic [15:0] pins_s;
    logic [12:0] strap_s; // synchronised strap field
    logic warm_s; // warm reset level, low holds
    logic sys_s; // system reset level, low holds
    logic secure_s; // secure device strap
    logic rst_hold; // any device reset still applied
    bmds_sync #(.WIDTH(16)) u_sync (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_async({i_secure_device, i_system_reset_n, i_warm_reset_n, i_boot_strap_config}),
        .o_sync(pins_s)
    );
    assign strap_s = pins_s[12:0];
    assign warm_s = pins_s[13];
    assign sys_s = pins_s[14];
    assign secure_s = pins_s[15];
    // local core resets are not part of this term
    assign rst_hold = !(warm_s && sys_s); // RULE2
    // sequence state
    bmds_pkg::bmds_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt; // word counter inside a step
    logic [12:0] dsw_r, dsw_nxt; // device status word
    logic secure_r, secure_nxt; // secure mode latched at release
    logic [6:0] prev_r, prev_nxt; // mode of the last recorded boot
    logic [2:0] sptr_r, sptr_nxt; // progress stack slot
    // memory write port
    logic we_r, we_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic [31:0] data_r, data_nxt;
    // core control
    logic rel_r, rel_nxt; // cores out of boot reset
    logic [N_CORES-1:0] crst_r, crst_nxt;
    logic [31:0] pc_r, pc_nxt;
    logic csec_r, csec_nxt;
    logic [N_CORES-2:0] idle_r, idle_nxt;
    logic busy_r, busy_nxt; // core 0 has not yet reached the entry point
    logic lock_r, lock_nxt;
    logic viol_r, viol_nxt;
    // registered decode
    logic [6:0] ext_r, ext_nxt;
    logic pref_r, pref_nxt;
    logic [2:0] pmul_r, pmul_nxt;
    logic [6:0] dcfg_r, dcfg_nxt;
    // decoder results of the latched status word
    bmds_pkg::bmds_ext_t dec_ext;
    logic dec_pref;
    logic [2:0] dec_pmul;
    logic [6:0] dec_dcfg;
    logic in_region; // peripheral write lands in the reserved region
    // decode the latched value, not the live pins
    bmds_decode u_decode (
        .i_strap(dsw_r), // RULE7
        .o_ext_mode(dec_ext),
        .o_pll_ref_serdes(dec_pref),
        .o_pll_mult(dec_pmul),
        .o_dev_cfg(dec_dcfg)
    );
    assign in_region = (i_l2_addr >= `BMDS_REGION_BASE) && (i_l2_addr <= `BMDS_REGION_END);
    // next state of the boot sequence
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        dsw_nxt = dsw_r;
        secure_nxt = secure_r;
        prev_nxt = prev_r;
        sptr_nxt = sptr_r;
        we_nxt = 1'b0;
        addr_nxt = addr_r;
        data_nxt = data_r;
        rel_nxt = rel_r;
        pc_nxt = pc_r;
        csec_nxt = csec_r;
        idle_nxt = idle_r;
        busy_nxt = busy_r;
        lock_nxt = lock_r;
        ext_nxt = dec_ext;
        pref_nxt = dec_pref;
        pmul_nxt = dec_pmul;
        dcfg_nxt = dec_dcfg;
        // reserved region guarded from other masters while locked
        viol_nxt = lock_r && i_l2_wr && in_region; // RULE4
        // local resets only gate each core, controller keeps state
        crst_nxt = {N_CORES{rel_r}} & i_local_reset_n; // RULE2
        if (rst_hold) begin
            // device reset applied: cores held, sequence parked
            state_nxt = bmds_pkg::BMDS_ST_HOLD;
            cnt_nxt = 4'h0;
            rel_nxt = 1'b0;
            crst_nxt = '0;
            busy_nxt = 1'b1;
            idle_nxt = '0;
            lock_nxt = 1'b1; // RULE4
        end else begin
            case (state_r)
                bmds_pkg::BMDS_ST_HOLD: begin
                    // release seen, start without software help
                    state_nxt = bmds_pkg::BMDS_ST_LATCH; // RULE1
                end
                bmds_pkg::BMDS_ST_LATCH: begin
                    // straps caught at release into status word
                    dsw_nxt = strap_s; // RULE18
                    secure_nxt = secure_s;
                    cnt_nxt = 4'h0;
                    state_nxt = bmds_pkg::BMDS_ST_INIT;
                end
                bmds_pkg::BMDS_ST_INIT: begin
                    // parameter table: mode, straps, pll, config
                    we_nxt = 1'b1; // RULE3
                    addr_nxt = `BMDS_PARAM_TBL + {26'h0, cnt_r, 2'b00};
                    case (cnt_r[1:0])
                        2'h0: data_nxt = {25'h0, dec_ext};
                        2'h1: data_nxt = {19'h0, dsw_r};
                        2'h2: data_nxt = {28'h0, dec_pref, dec_pmul};
                        default: data_nxt = {25'h0, dec_dcfg};
                    endcase
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == `BMDS_PARAM_WORDS) begin
                        cnt_nxt = 4'h0;
                        state_nxt = bmds_pkg::BMDS_ST_VERSION;
                    end
                end
                bmds_pkg::BMDS_ST_VERSION: begin
                    // sixteen words of version string
                    we_nxt = 1'b1; // RULE5
                    addr_nxt = `BMDS_VERSION_BASE + {26'h0, cnt_r, 2'b00};
                    data_nxt = {VERSION_TAG, 4'h0, cnt_r};
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == 4'hF) begin
                        state_nxt = bmds_pkg::BMDS_ST_PROGRESS;
                    end
                end
                bmds_pkg::BMDS_ST_PROGRESS: begin
                    // record a copy only when the mode differs
                    if (dec_ext != prev_r) begin
                        we_nxt = 1'b1; // RULE6
                        addr_nxt = `BMDS_PROGRESS_BASE + {27'h0, sptr_r, 2'b00};
                        data_nxt = {12'h0, dsw_r, dec_ext};
                        prev_nxt = dec_ext;
                        sptr_nxt = sptr_r + 3'h1; // eight slots wrap
                    end
                    state_nxt = bmds_pkg::BMDS_ST_RELEASE;
                end
                bmds_pkg::BMDS_ST_RELEASE: begin
                    // core 0 to rom, others into the idle loop
                    rel_nxt = 1'b1; // RULE14
                    csec_nxt = secure_r; // RULE16
                    pc_nxt = secure_r ? SECURE_ROM_BASE : `BMDS_ROM_BASE;
                    idle_nxt = '1; // RULE15
                    state_nxt = bmds_pkg::BMDS_ST_RUN;
                end
                bmds_pkg::BMDS_ST_RUN: begin
                    // entry point taken once; secure needs authentication
                    if (i_entry_valid && busy_r && (!secure_r || i_auth_ok)) begin
                        pc_nxt = i_entry_point; // RULE14 RULE16
                        busy_nxt = 1'b0;
                        lock_nxt = 1'b0; // RULE4
                    end
                    // interrupt from core 0 ends the idle loop
                    idle_nxt = idle_r & ~i_core0_ipi; // RULE15
                end
                default: state_nxt = bmds_pkg::BMDS_ST_HOLD;
            endcase
        end
    end
    // registers of the sequence
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= bmds_pkg::BMDS_ST_HOLD;
            cnt_r <= 4'h0;
            dsw_r <= 13'h0000;
            secure_r <= 1'b0;
            prev_r <= `BMDS_EXT_NONE;
            sptr_r <= 3'h0;
            we_r <= 1'b0;
            addr_r <= 32'h0000_0000;
            data_r <= 32'h0000_0000;
            rel_r <= 1'b0;
            crst_r <= '0;
            pc_r <= 32'h0000_0000;
            csec_r <= 1'b0;
            idle_r <= '0;
            busy_r <= 1'b1;
            lock_r <= 1'b1;
            viol_r <= 1'b0;
            ext_r <= 7'h00;
            pref_r <= 1'b0;
            pmul_r <= 3'h0;
            dcfg_r <= 7'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            dsw_r <= dsw_nxt;
            secure_r <= secure_nxt;
            prev_r <= prev_nxt;
            sptr_r <= sptr_nxt;
            we_r <= we_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            rel_r <= rel_nxt;
            crst_r <= crst_nxt;
            pc_r <= pc_nxt;
            csec_r <= csec_nxt;
            idle_r <= idle_nxt;
            busy_r <= busy_nxt;
            lock_r <= lock_nxt;
            viol_r <= viol_nxt;
            ext_r <= ext_nxt;
            pref_r <= pref_nxt;
            pmul_r <= pmul_nxt;
            dcfg_r <= dcfg_nxt;
        end
    end
    // outputs straight from flops
    assign o_boot_busy = busy_r;
    assign o_device_status_word = dsw_r;
    assign o_ext_mode = ext_r;
    assign o_pll_ref_serdes = pref_r;
    assign o_pll_mult = pmul_r;
    assign o_dev_cfg = dcfg_r;
    assign o_mem_we = we_r;
    assign o_mem_addr = addr_r;
    assign o_mem_data = data_r;
    assign o_core_rst_n = crst_r;
    assign o_core0_pc = pc_r;
    assign o_core0_secure = csec_r;
    assign o_core_idle = idle_r;
    assign o_region_lock = lock_r;
    assign o_l2_violation = viol_r;
    // core release seen one cycle after the release step
    sequence s_release;
        state_r == bmds_pkg::BMDS_ST_RELEASE && !rst_hold;
    endsequence
    sequence s_at_rom;
        rel_r && o_core0_pc == `BMDS_ROM_BASE && !o_core0_secure;
    endsequence
    // device reset released starts the sequence
    property p_start;
        @(posedge i_clock) disable iff (!i_reset_n)
        $fell(rst_hold) |-> state_r == bmds_pkg::BMDS_ST_HOLD
            ##1 state_r == bmds_pkg::BMDS_ST_LATCH;
    endproperty
    a_start: assert property (p_start) else $error("boot did not start"); // RULE1
    // local reset change leaves the sequence alone
    property p_local;
        @(posedge i_clock) disable iff (!i_reset_n)
        $changed(i_local_reset_n) && state_r == bmds_pkg::BMDS_ST_RUN
            && !rst_hold |=> state_r == bmds_pkg::BMDS_ST_RUN && $stable(dsw_r);
    endproperty
    a_local: assert property (p_local) else $error("local reset disturbed boot"); // RULE2
    // parameter table write starts at its base on entry
    property p_init;
        @(posedge i_clock) disable iff (!i_reset_n)
        $rose(state_r == bmds_pkg::BMDS_ST_INIT) && !rst_hold
            |=> o_mem_we && o_mem_addr == `BMDS_PARAM_TBL;
    endproperty
    a_init: assert property (p_init) else $error("parameter table not written"); // RULE3
    // write into locked region flagged next cycle
    property p_lock;
        @(posedge i_clock) disable iff (!i_reset_n)
        o_region_lock && i_l2_wr && i_l2_addr == `BMDS_REGION_END
            |=> o_l2_violation;
    endproperty
    a_lock: assert property (p_lock) else $error("region write not flagged"); // RULE4
    // version words stay inside their 0x40 bytes
    property p_version;
        @(posedge i_clock) disable iff (!i_reset_n)
        state_r == bmds_pkg::BMDS_ST_VERSION && !rst_hold |=> o_mem_we
            && o_mem_addr >= `BMDS_VERSION_BASE
            && o_mem_addr < `BMDS_VERSION_BASE + `BMDS_VERSION_BYTES;
    endproperty
    a_version: assert property (p_version) else $error("version write misplaced"); // RULE5
    // mode change leaves a copy in the progress stack
    property p_progress;
        @(posedge i_clock) disable iff (!i_reset_n)
        state_r == bmds_pkg::BMDS_ST_PROGRESS && !rst_hold && dec_ext != prev_r
            |=> o_mem_we && o_mem_data[6:0] == $past(dec_ext)
            && o_mem_addr >= `BMDS_PROGRESS_BASE
            && o_mem_addr < `BMDS_PROGRESS_BASE + `BMDS_PROGRESS_BYTES;
    endproperty
    a_progress: assert property (p_progress) else $error("progress copy missing"); // RULE6
    // pcie code gives extended mode thirty
    property p_decode;
        @(posedge i_clock) disable iff (!i_reset_n)
        state_r == bmds_pkg::BMDS_ST_RUN && $stable(dsw_r) && dsw_r[2:0] == 3'h4
            |-> o_ext_mode == 7'h1E;
    endproperty
    a_decode: assert property (p_decode) else $error("pcie decode wrong"); // RULE12
    // public boot: core 0 released at the rom base
    property p_public;
        @(posedge i_clock) disable iff (!i_reset_n)
        s_release ##0 !secure_r |=> s_at_rom ##0 o_core_idle == '1;
    endproperty
    a_public: assert property (p_public) else $error("core 0 not at rom"); // RULE14
    // interrupt from core 0 clears the idle bit
    property p_wake;
        @(posedge i_clock) disable iff (!i_reset_n)
        state_r == bmds_pkg::BMDS_ST_RUN && !rst_hold && i_core0_ipi[0]
            |=> !o_core_idle[0];
    endproperty
    a_wake: assert property (p_wake) else $error("idle core not woken"); // RULE15
    // secure boot holds the rom address until authenticated
    property p_secure;
        @(posedge i_clock) disable iff (!i_reset_n)
        state_r == bmds_pkg::BMDS_ST_RUN && secure_r && busy_r && !i_auth_ok
            && !rst_hold |=> $stable(o_core0_pc) && o_core0_pc == SECURE_ROM_BASE;
    endproperty
    a_secure: assert property (p_secure) else $error("unauthenticated jump"); // RULE16
endmodule
`default_nettype wire

// ==== tb/bmds_core_model.sv ====
// Purpose: model of core 0 handing over the entry point
// Assumes: core 0 runs on i_clock once released
// Notes: entry raised on the fourth falling edge after release
`default_nettype none
module bmds_core_model (
    input wire logic i_clock,
    input wire logic i_core0_rst_n,
    input wire logic i_auth_en,
    output logic o_entry_valid,
    output logic [31:0] o_entry_point,
    output logic o_auth_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0; // cycles since release
    assign o_entry_point = 32'h0080_0100; // fixed entry of the image
    // quiet until released, so no stale entry reaches a fresh boot
    initial begin
        o_entry_valid = 1'b0;
        o_auth_ok = 1'b0;
    end
    // loader finishes a few cycles after release, then holds entry
    always @(negedge i_clock) begin
        cnt <= i_core0_rst_n ? cnt + 1 : 0;
        o_entry_valid <= i_core0_rst_n && cnt >= 3;
        o_auth_ok <= i_auth_en;
    end
endmodule
`default_nettype wire

// ==== tb/bmds_top_tb.sv ====
// Purpose: self checking bench of the boot sequencer
// Assumes: two cores, default rom bases
// Notes: inputs change at the falling edge
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module bmds_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, warm_n = 1'b1, sys_n = 1'b1, sec = 1'b0, auth = 1'b1;
    logic ipi = 1'b0, l2_wr = 1'b0, busy, pref, we, csec, idle, lock, viol, ev, aok;
    logic [12:0] strap = 13'h0000, dsw;
    logic [12:0] tbl [10] = '{13'h0010, 13'h0030, 13'h0001, 13'h1C02, 13'h0303,
        13'h0004, 13'h0405, 13'h0005, 13'h0006, 13'h1FFF};
    logic [1:0] lrst_n = 2'b11, crst_n;
    logic [31:0] l2_addr = 32'h0, maddr, mdata, pc, ep;
    logic [6:0] ext, dcfg, prev = 7'h7F;
    logic [2:0] pmul;
    logic [19:0] lastp;
    int error_cnt = 0, comparisons = 0, nver, nprog, nall;
    bmds_top uut (.i_clock(clk), .i_reset_n(rst_n), .i_boot_strap_config(strap),
        .i_warm_reset_n(warm_n), .i_system_reset_n(sys_n), .i_secure_device(sec),
        .i_local_reset_n(lrst_n), .i_entry_valid(ev), .i_entry_point(ep), .i_auth_ok(aok),
        .i_core0_ipi(ipi), .i_l2_wr(l2_wr), .i_l2_addr(l2_addr), .o_boot_busy(busy),
        .o_device_status_word(dsw), .o_ext_mode(ext), .o_pll_ref_serdes(pref),
        .o_pll_mult(pmul), .o_dev_cfg(dcfg), .o_mem_we(we), .o_mem_addr(maddr),
        .o_mem_data(mdata), .o_core_rst_n(crst_n), .o_core0_pc(pc),
        .o_core0_secure(csec), .o_core_idle(idle), .o_region_lock(lock),
        .o_l2_violation(viol));
    bmds_core_model core0 (.i_clock(clk), .i_core0_rst_n(crst_n[0]), .i_auth_en(auth),
        .o_entry_valid(ev), .o_entry_point(ep), .o_auth_ok(aok));
    always #25 clk = ~clk;
    // tally memory writes by area
    always @(posedge clk) begin
        if (we === 1'b1) begin
            nall <= nall + 1;
            nver <= nver + (maddr >= 32'h0087_2DC0 && maddr < 32'h0087_2E00);
            nprog <= nprog + (maddr >= 32'h0087_32E0 && maddr < 32'h0087_3300);
            lastp <= mdata[19:0];
        end
    end
    // expected extended mode of a strap value
    function automatic logic [6:0] xm(input logic [12:0] s);
        case (s[2:0])
            3'h0: return s[5:4] == 2'h1 ? 7'h46 : 7'h64;
            3'h1: return 7'h14;
            3'h2, 3'h3: return 7'h0A;
            3'h4: return 7'h1E;
            3'h5: return s[10] ? 7'h29 : 7'h28;
            3'h6: return 7'h32;
            default: return 7'h3C;
        endcase
    endfunction
    // one boot: kind 0 power-on, 1 warm, 2 system reset
    task automatic boot(input logic [12:0] s, input int kind, input logic sd);
        logic [2:0] d;
        int n, a0, v0, p0;
        d = s[2:0];
        strap = s;
        sec = sd;
        auth = ~sd;
        a0 = nall; // tallies run on, keep a baseline
        v0 = nver;
        p0 = nprog;
        if (kind != 0) begin
            warm_n = kind != 1;
            sys_n = kind != 2;
            repeat (4) @(negedge clk);
            warm_n = 1'b1;
            sys_n = 1'b1;
        end
        for (n = 0; n < 99 && crst_n[0] !== 1'b1; n++) @(negedge clk);
        `CHK(crst_n[0], 1'b1)
        strap = ~s; // late strap change must be ignored
        `CHK(pc, sd ? 32'h20B1_0000 : 32'h20B0_0000)
        `CHK(csec, sd)
        `CHK(idle, 1'b1)
        `CHK(lock, 1'b1)
        // secure: no entry without authentication, region guarded
        if (sd) begin
            repeat (8) @(negedge clk);
            `CHK(busy, 1'b1)
            l2_wr = 1'b1;
            l2_addr = 32'h0087_FFFF;
            @(negedge clk);
            l2_addr = 32'h0087_2DBF;
            `CHK(viol, 1'b1)
            @(negedge clk);
            l2_wr = 1'b0;
            `CHK(viol, 1'b0)
            auth = 1'b1;
        end
        for (n = 0; n < 99 && busy !== 1'b0; n++) @(negedge clk);
        `CHK(busy, 1'b0)
        `CHK(dsw, s)
        `CHK(ext, xm(s))
        `CHK(pref, d == 3'h3)
        `CHK(pmul, d == 3'h2 ? s[12:10] : d == 3'h3 ? {1'b0, s[9:8]} : 3'h0)
        `CHK(dcfg, s[9:3])
        `CHK(pc, 32'h0080_0100)
        `CHK(lock, 1'b0)
        `CHK(nver - v0, 16)
        `CHK(nall - a0, 20 + (xm(s) != prev))
        `CHK(nprog - p0, xm(s) != prev)
        if (xm(s) != prev) `CHK(lastp, {s, xm(s)})
        prev = xm(s);
        $display("boot %h done", s);
    endtask
    // local reset of core 1, interrupt and unlocked write
    task automatic cores;
        lrst_n = 2'b01;
        @(negedge clk);
        `CHK(crst_n, 2'b01)
        `CHK(busy, 1'b0)
        `CHK(dsw, 13'h0001)
        lrst_n = 2'b11;
        ipi = 1'b1;
        l2_wr = 1'b1;
        l2_addr = 32'h0087_2DC0;
        @(negedge clk);
        ipi = 1'b0;
        l2_wr = 1'b0;
        `CHK(viol, 1'b0)
        @(negedge clk);
        `CHK(crst_n, 2'b11)
        `CHK(idle, 1'b0)
        $display("cores done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        boot(13'h0000, 0, 1'b0);
        foreach (tbl[i]) boot(tbl[i], i == 9 ? 2 : 1, 1'b0);
        boot(13'h0001, 1, 1'b1);
        cores();
        print_verdict();
    end
    // watchdog, far beyond a dozen boots
    initial begin
        #2000000;
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
